// ### liu_port_loop_config_pkg.sv
// Register map, field layout, reset values and timing constants of the port and loop register bank
package liu_port_loop_config_pkg;

	// ======================================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_RCLK_ROUTE_67 = 8'hd5;
	localparam logic [7:0] IDX_RCLK_ROUTE_8  = 8'hd6;
	localparam logic [7:0] IDX_LOOP_DET_TIME = 8'hd7;
	localparam logic [7:0] IDX_REMOTE_AUTO   = 8'hd9;
	localparam logic [7:0] IDX_LOOP_IRQ_MASK = 8'hde;
	localparam logic [7:0] IDX_CLK_IRQ_MASK  = 8'hdf;
	localparam logic [7:0] IDX_RAIL_MODE     = 8'he0;
	localparam logic [7:0] IDX_CLK_IRQ_STAT  = 8'he1;
	localparam logic [7:0] IDX_LOOP_IRQ_STAT = 8'he2;

	// ======================================================================
	// Reset values
	localparam logic [7:0] RST_RCLK_ROUTE_67 = 8'h65;
	localparam logic [7:0] RST_RCLK_ROUTE_8  = 8'h07;
	localparam logic [7:0] RST_LOOP_DET_TIME = 8'h00;
	localparam logic [7:0] RST_REMOTE_AUTO   = 8'h00;
	localparam logic [7:0] RST_LOOP_IRQ_MASK = 8'h00;
	localparam logic [7:0] RST_CLK_IRQ_MASK  = 8'h00;
	localparam logic [7:0] RST_RAIL_MODE     = 8'h00;

	// ======================================================================
	// Writable bits of each register
	localparam logic [7:0] WM_RCLK_ROUTE_67 = 8'h77;
	localparam logic [7:0] WM_RCLK_ROUTE_8  = 8'h07;
	localparam logic [7:0] WM_LOOP_DET_TIME = 8'h30;
	localparam logic [7:0] WM_REMOTE_AUTO   = 8'h01;
	localparam logic [7:0] WM_LOOP_IRQ      = 8'h03;
	localparam logic [7:0] WM_CLK_IRQ       = 8'h18;
	localparam logic [7:0] WM_RAIL_MODE     = 8'h03;

	// ======================================================================
	// Field positions
	localparam int OUT7_SEL_LSB  = 4;
	localparam int OUT6_SEL_LSB  = 0;
	localparam int OUT8_SEL_LSB  = 0;
	localparam int DET_TIME_LSB  = 4;
	localparam int LINE_AUTO_BIT = 0;
	localparam int LOOP_UP_BIT   = 1;
	localparam int LOOP_DOWN_BIT = 0;
	localparam int TX_SW1_BIT    = 4;
	localparam int TX_SW0_BIT    = 3;
	localparam int RX_DUAL_BIT   = 1;
	localparam int TX_DUAL_BIT   = 0;

	// ======================================================================
	// Loop detection time selections and thresholds
	localparam logic [1:0] DET_16_PATTERNS = 2'h0;
	localparam logic [1:0] DET_32_PATTERNS = 2'h1;
	localparam logic [1:0] DET_4_SECONDS   = 2'h2;
	localparam logic [1:0] DET_5_SECONDS   = 2'h3;
	localparam logic [31:0] PATTERNS_SHORT = 32'h0000_0010;
	localparam logic [31:0] PATTERNS_LONG  = 32'h0000_0020;
	localparam longint CLK_HZ         = 100_000_000;
	localparam longint DET_SHORT_SEC  = 4;
	localparam longint DET_LONG_SEC   = 5;
	localparam longint DET_SHORT_CYC  = DET_SHORT_SEC * CLK_HZ;
	localparam longint DET_LONG_CYC   = DET_LONG_SEC * CLK_HZ;

endpackage

// ### liu_port_loop_config_regs.sv
// Port routing, loop detection and interrupt register bank with Avalon-MM slave
//
// Overview of operation
// - Bits 6:4 route channel n+1 to output 7
// - Bits 2:0 route channel n+1 to output 6
// - Second route register bits 2:0 feed output 8
// - Time code 00 needs 16 consecutive patterns
// - Time code 01 needs 32 consecutive patterns
// - Time code 10 needs four seconds valid
// - Time code 11 needs five seconds valid
// - Line auto switch moves remote loop, unless local
// - Loop code interrupt only when unmasked
// - Mask bits 4,3 gate clock switch events
// - Bit 1 selects receive dual rail
// - Bit 0 selects transmit dual rail
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
module liu_port_loop_config_regs #(
	parameter longint DET_SHORT_CYCLES = liu_port_loop_config_pkg::DET_SHORT_CYC,
	parameter longint DET_LONG_CYCLES  = liu_port_loop_config_pkg::DET_LONG_CYC
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// Avalon-MM slave
	input  wire logic [9:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [3:0]  i_byteenable,
	input  wire logic [31:0] i_writedata,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	// Channel recovered clocks and routed outputs
	input  wire logic [7:0]  i_chan_rclk,
	output logic             o_recovered_clock_out_6,
	output logic             o_recovered_clock_out_7,
	output logic             o_recovered_clock_out_8,
	// In-band loop code detector
	input  wire logic        i_loop_pattern_valid,
	input  wire logic        i_loop_pattern_tick,
	input  wire logic        i_loop_code_is_up,
	input  wire logic        i_local_loop_enable,
	output logic             o_remote_loop,
	// Transmit clock source switch events
	input  wire logic [1:0]  i_tx_clock_switch_event,
	// Framer rail modes and interrupt
	output logic             o_rx_framer_dual_rail,
	output logic             o_tx_framer_dual_rail,
	output logic             o_irq
);

	// ======================================================================
	// State
	typedef struct packed {
		logic        wait_q;
		logic [7:0]  rdata;
		logic [7:0]  route_67;
		logic [7:0]  route_8;
		logic [7:0]  det_time;
		logic [7:0]  auto_sw;
		logic [7:0]  loop_mask;
		logic [7:0]  clk_mask;
		logic [7:0]  rail;
		logic [7:0]  clk_stat;
		logic [7:0]  loop_stat;
		logic [2:0]  rclk;
		logic        remote;
		logic        irq;
		logic [31:0] cnt;
		logic        det;
		logic        code_up;
	} state_t;

	state_t st_q;
	state_t st_d;

	// ======================================================================
	// Helpers
	function automatic logic pick(input logic [7:0] clks, input logic [2:0] sel);
		pick = clks[sel];
	endfunction

	function automatic logic hit(input logic [9:0] addr, input logic [7:0] idx);
		hit = (addr[1:0] == 2'h0) && (addr[9:2] == idx);
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
			input logic [7:0] wm);
		merge = (old & ~wm) | (wd & wm);
	endfunction

	logic        req;
	logic        accept;
	logic        wr_en;
	logic [7:0]  wd;
	logic [1:0]  mode;
	logic [31:0] thresh;
	logic        step;
	logic        fire;
	logic [7:0]  rd_val;

	assign req    = i_read || i_write;
	assign accept = req && !st_q.wait_q;
	assign wr_en  = accept && i_write && i_byteenable[0];
	assign wd     = i_writedata[7:0];
	assign mode   = st_q.det_time[liu_port_loop_config_pkg::DET_TIME_LSB +: 2];

	// ======================================================================
	// Loop detection threshold
	always_comb begin
		case (mode)
			liu_port_loop_config_pkg::DET_16_PATTERNS: begin
				thresh = liu_port_loop_config_pkg::PATTERNS_SHORT;
			end
			liu_port_loop_config_pkg::DET_32_PATTERNS: begin
				thresh = liu_port_loop_config_pkg::PATTERNS_LONG;
			end
			liu_port_loop_config_pkg::DET_4_SECONDS: begin
				thresh = 32'(DET_SHORT_CYCLES);
			end
			default: begin
				thresh = 32'(DET_LONG_CYCLES);
			end
		endcase
	end

	// Pattern modes count patterns, time modes count cycles of continuous validity
	assign step = i_loop_pattern_valid && (mode[1] || i_loop_pattern_tick);
	assign fire = step && !st_q.det && (st_q.code_up == i_loop_code_is_up)
		&& (st_q.cnt == thresh - 32'h1);

	// ======================================================================
	// Read mux
	always_comb begin
		rd_val = 8'h00;
		if (hit(i_address, liu_port_loop_config_pkg::IDX_RCLK_ROUTE_67)) begin
			rd_val = st_q.route_67;
		end else if (hit(i_address, liu_port_loop_config_pkg::IDX_RCLK_ROUTE_8)) begin
			rd_val = st_q.route_8;
		end else if (hit(i_address, liu_port_loop_config_pkg::IDX_LOOP_DET_TIME)) begin
			rd_val = st_q.det_time;
		end else if (hit(i_address, liu_port_loop_config_pkg::IDX_REMOTE_AUTO)) begin
			rd_val = st_q.auto_sw;
		end else if (hit(i_address, liu_port_loop_config_pkg::IDX_LOOP_IRQ_MASK)) begin
			rd_val = st_q.loop_mask;
		end else if (hit(i_address, liu_port_loop_config_pkg::IDX_CLK_IRQ_MASK)) begin
			rd_val = st_q.clk_mask;
		end else if (hit(i_address, liu_port_loop_config_pkg::IDX_RAIL_MODE)) begin
			rd_val = st_q.rail;
		end else if (hit(i_address, liu_port_loop_config_pkg::IDX_CLK_IRQ_STAT)) begin
			rd_val = st_q.clk_stat;
		end else if (hit(i_address, liu_port_loop_config_pkg::IDX_LOOP_IRQ_STAT)) begin
			rd_val = st_q.loop_stat;
		end
	end

	// ======================================================================
	// Next state
	always_comb begin
		st_d = st_q;
		// One wait cycle per access so that read data come from a flop
		st_d.wait_q = !(req && st_q.wait_q);
		if (req && st_q.wait_q && i_read) begin
			st_d.rdata = rd_val;
		end
		// Writes mask off reserved bits
		if (wr_en) begin
			if (hit(i_address, liu_port_loop_config_pkg::IDX_RCLK_ROUTE_67)) begin
				st_d.route_67 = merge(st_q.route_67, wd,
					liu_port_loop_config_pkg::WM_RCLK_ROUTE_67);
			end
			if (hit(i_address, liu_port_loop_config_pkg::IDX_RCLK_ROUTE_8)) begin
				st_d.route_8 = merge(st_q.route_8, wd, liu_port_loop_config_pkg::WM_RCLK_ROUTE_8);
			end
			if (hit(i_address, liu_port_loop_config_pkg::IDX_LOOP_DET_TIME)) begin
				st_d.det_time = merge(st_q.det_time, wd,
					liu_port_loop_config_pkg::WM_LOOP_DET_TIME);
			end
			if (hit(i_address, liu_port_loop_config_pkg::IDX_REMOTE_AUTO)) begin
				st_d.auto_sw = merge(st_q.auto_sw, wd, liu_port_loop_config_pkg::WM_REMOTE_AUTO);
			end
			if (hit(i_address, liu_port_loop_config_pkg::IDX_LOOP_IRQ_MASK)) begin
				st_d.loop_mask = merge(st_q.loop_mask, wd, liu_port_loop_config_pkg::WM_LOOP_IRQ);
			end
			if (hit(i_address, liu_port_loop_config_pkg::IDX_CLK_IRQ_MASK)) begin
				st_d.clk_mask = merge(st_q.clk_mask, wd, liu_port_loop_config_pkg::WM_CLK_IRQ);
			end
			if (hit(i_address, liu_port_loop_config_pkg::IDX_RAIL_MODE)) begin
				st_d.rail = merge(st_q.rail, wd, liu_port_loop_config_pkg::WM_RAIL_MODE);
			end
			if (hit(i_address, liu_port_loop_config_pkg::IDX_CLK_IRQ_STAT)) begin
				st_d.clk_stat = st_q.clk_stat & ~(wd & liu_port_loop_config_pkg::WM_CLK_IRQ);
			end
			if (hit(i_address, liu_port_loop_config_pkg::IDX_LOOP_IRQ_STAT)) begin
				st_d.loop_stat = st_q.loop_stat & ~(wd & liu_port_loop_config_pkg::WM_LOOP_IRQ);
			end
		end
		// Events set after the clear so a same-cycle event survives
		st_d.clk_stat[liu_port_loop_config_pkg::TX_SW1_BIT] =
			st_d.clk_stat[liu_port_loop_config_pkg::TX_SW1_BIT] || i_tx_clock_switch_event[1];
		st_d.clk_stat[liu_port_loop_config_pkg::TX_SW0_BIT] =
			st_d.clk_stat[liu_port_loop_config_pkg::TX_SW0_BIT] || i_tx_clock_switch_event[0];
		// Loop code run counter restarts when validity drops or the code changes
		st_d.code_up = i_loop_code_is_up;
		if (!i_loop_pattern_valid || (st_q.code_up != i_loop_code_is_up)) begin
			st_d.cnt = 32'h0;
			st_d.det = 1'b0;
		end else if (step && !st_q.det) begin
			st_d.cnt = st_q.cnt + 32'h1;
			st_d.det = fire;
		end
		if (fire) begin
			if (i_loop_code_is_up) begin
				st_d.loop_stat[liu_port_loop_config_pkg::LOOP_UP_BIT] = 1'b1;
			end else begin
				st_d.loop_stat[liu_port_loop_config_pkg::LOOP_DOWN_BIT] = 1'b1;
			end
			// Local loop has priority over line-triggered remote loop
			if (st_q.auto_sw[liu_port_loop_config_pkg::LINE_AUTO_BIT] && !i_local_loop_enable) begin
				st_d.remote = i_loop_code_is_up;
			end
		end
		// Clock routing, registered per output
		st_d.rclk[0] = pick(i_chan_rclk,
			st_q.route_67[liu_port_loop_config_pkg::OUT6_SEL_LSB +: 3]);
		st_d.rclk[1] = pick(i_chan_rclk,
			st_q.route_67[liu_port_loop_config_pkg::OUT7_SEL_LSB +: 3]);
		st_d.rclk[2] = pick(i_chan_rclk,
			st_q.route_8[liu_port_loop_config_pkg::OUT8_SEL_LSB +: 3]);
		// Interrupt, set and mask share layout; one cycle behind the status
		st_d.irq = |(st_q.loop_stat & ~st_q.loop_mask)
			|| |(st_q.clk_stat & ~st_q.clk_mask);
	end

	// ======================================================================
	// Registers
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_q           <= '0;
			st_q.wait_q    <= 1'b1;
			st_q.route_67  <= liu_port_loop_config_pkg::RST_RCLK_ROUTE_67;
			st_q.route_8   <= liu_port_loop_config_pkg::RST_RCLK_ROUTE_8;
			st_q.det_time  <= liu_port_loop_config_pkg::RST_LOOP_DET_TIME;
			st_q.auto_sw   <= liu_port_loop_config_pkg::RST_REMOTE_AUTO;
			st_q.loop_mask <= liu_port_loop_config_pkg::RST_LOOP_IRQ_MASK;
			st_q.clk_mask  <= liu_port_loop_config_pkg::RST_CLK_IRQ_MASK;
			st_q.rail      <= liu_port_loop_config_pkg::RST_RAIL_MODE;
		end else begin
			st_q <= st_d;
		end
	end

	// ======================================================================
	// Outputs
	assign o_readdata              = {24'h000000, st_q.rdata};
	assign o_waitrequest           = st_q.wait_q;
	assign o_recovered_clock_out_6 = st_q.rclk[0];
	assign o_recovered_clock_out_7 = st_q.rclk[1];
	assign o_recovered_clock_out_8 = st_q.rclk[2];
	assign o_remote_loop           = st_q.remote;
	assign o_rx_framer_dual_rail   = st_q.rail[liu_port_loop_config_pkg::RX_DUAL_BIT];
	assign o_tx_framer_dual_rail   = st_q.rail[liu_port_loop_config_pkg::TX_DUAL_BIT];
	assign o_irq                   = st_q.irq;

	// ======================================================================
	// Assertions
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	sequence s_fire_mode(logic [1:0] m);
		fire && mode == m;
	endsequence

	property p_route7;
		1 |=> o_recovered_clock_out_7 == $past(i_chan_rclk[st_q.route_67[6:4]]);
	endproperty
	a_route7: assert property (p_route7) else $error("output 7 routing wrong");

	property p_route6;
		1 |=> o_recovered_clock_out_6 == $past(i_chan_rclk[st_q.route_67[2:0]]);
	endproperty
	a_route6: assert property (p_route6) else $error("output 6 routing wrong");

	property p_route8;
		1 |=> o_recovered_clock_out_8 == $past(i_chan_rclk[st_q.route_8[2:0]]);
	endproperty
	a_route8: assert property (p_route8) else $error("output 8 routing wrong");

	property p_det16;
		s_fire_mode(2'h0) |-> st_q.cnt == 32'd15 ##1 (st_q.loop_stat[1] || st_q.loop_stat[0]);
	endproperty
	a_det16: assert property (p_det16) else $error("16 pattern detect count wrong");

	property p_det32;
		s_fire_mode(2'h1) |-> st_q.cnt == 32'd31 ##1 (st_q.loop_stat[1] || st_q.loop_stat[0]);
	endproperty
	a_det32: assert property (p_det32) else $error("32 pattern detect count wrong");

	property p_det_time;
		(fire && mode[1]) |-> st_q.cnt == 32'(mode[0] ? DET_LONG_CYCLES : DET_SHORT_CYCLES) - 32'd1;
	endproperty
	a_det_time: assert property (p_det_time) else $error("timed detect count wrong");

	property p_remote;
		$changed(o_remote_loop) |-> $past(fire && st_q.auto_sw[0] && !i_local_loop_enable);
	endproperty
	a_remote: assert property (p_remote) else $error("remote loop moved unexpectedly");

	property p_irq;
		1 |=> o_irq == $past(|(st_q.loop_stat & ~st_q.loop_mask) || |(st_q.clk_stat & ~st_q.clk_mask));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt does not follow status and mask");

	property p_event_wins;
		i_tx_clock_switch_event[1] |=> st_q.clk_stat[4];
	endproperty
	a_event_wins: assert property (p_event_wins) else $error("switch event lost");

	property p_rail;
		(wr_en && hit(i_address, liu_port_loop_config_pkg::IDX_RAIL_MODE)) |=>
			o_rx_framer_dual_rail == $past(i_writedata[1])
			&& o_tx_framer_dual_rail == $past(i_writedata[0]);
	endproperty
	a_rail: assert property (p_rail) else $error("rail mode write not applied");

	property p_reserved;
		1 |-> st_q.route_67[7] == 1'b0 && st_q.route_67[3] == 1'b0 && st_q.auto_sw[7:1] == 7'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule // liu_port_loop_config_regs

// ### liu_port_loop_config_regs_tb.sv
// Self-checking testbench of the port and loop register bank
`timescale 1ns/1ns
module liu_port_loop_config_regs_tb;
	// ======================================================================
	// Shortened detection times keep the run brief
	localparam longint SHORT_CYC = 40;
	localparam longint LONG_CYC  = 50;

	logic        i_clk                   = 1'b0;
	logic        i_rst_b                 = 1'b0;
	logic [9:0]  i_address               = 10'h000;
	logic        i_read                  = 1'b0;
	logic        i_write                 = 1'b0;
	logic [3:0]  i_byteenable            = 4'h0;
	logic [31:0] i_writedata             = 32'h0;
	logic [31:0] o_readdata;
	logic        o_waitrequest;
	logic [7:0]  i_chan_rclk             = 8'h00;
	logic        o_recovered_clock_out_6;
	logic        o_recovered_clock_out_7;
	logic        o_recovered_clock_out_8;
	logic        i_loop_pattern_valid    = 1'b0;
	logic        i_loop_pattern_tick     = 1'b0;
	logic        i_loop_code_is_up       = 1'b0;
	logic        i_local_loop_enable     = 1'b0;
	logic        o_remote_loop;
	logic [1:0]  i_tx_clock_switch_event = 2'h0;
	logic        o_rx_framer_dual_rail;
	logic        o_tx_framer_dual_rail;
	logic        o_irq;
	int          num_errors              = 0;
	int          comparisons             = 0;
	int          cycles                  = 0;
	int          rmodel [int];
	int          wmask [int];
	int          lstat                   = 0;
	int          cstat                   = 0;
	int          rem_exp                 = 0;
	logic [31:0] rd;

	liu_port_loop_config_regs #(.DET_SHORT_CYCLES(SHORT_CYC), .DET_LONG_CYCLES(LONG_CYC))
	i_liu_port_loop_config_regs (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_byteenable(i_byteenable),
		.i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
		.i_chan_rclk(i_chan_rclk), .o_recovered_clock_out_6(o_recovered_clock_out_6),
		.o_recovered_clock_out_7(o_recovered_clock_out_7),
		.o_recovered_clock_out_8(o_recovered_clock_out_8),
		.i_loop_pattern_valid(i_loop_pattern_valid), .i_loop_pattern_tick(i_loop_pattern_tick),
		.i_loop_code_is_up(i_loop_code_is_up), .i_local_loop_enable(i_local_loop_enable),
		.o_remote_loop(o_remote_loop), .i_tx_clock_switch_event(i_tx_clock_switch_event),
		.o_rx_framer_dual_rail(o_rx_framer_dual_rail),
		.o_tx_framer_dual_rail(o_tx_framer_dual_rail), .o_irq(o_irq));

	// ======================================================================
	// Clock and hang guard
	always #5 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			finish_test();
		end
	end

	// ======================================================================
	// Comparison and reporting
	task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_pin(input logic got, input logic exp);
		check_reg({31'h0, got}, {31'h0, exp});
	endtask

	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	function automatic logic irq_exp();
		irq_exp = |(lstat & ~rmodel[liu_port_loop_config_pkg::IDX_LOOP_IRQ_MASK] & 3) |
			|(cstat & ~rmodel[liu_port_loop_config_pkg::IDX_CLK_IRQ_MASK] & 'h18);
	endfunction

	// ======================================================================
	// Avalon-MM master: request held until waitrequest is seen low at an edge
	task automatic bus_access(input logic [9:0] addr, input logic wr, input logic [31:0] data,
		input logic [3:0] be, output logic [31:0] rdata);
		int n;
		n = 0;
		@(posedge i_clk);
		i_address <= addr;
		i_write <= wr;
		i_read <= ~wr;
		i_writedata <= data;
		i_byteenable <= be;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			num_errors++;
		rdata = o_readdata;
		i_write <= 1'b0;
		i_read <= 1'b0;
	endtask

	task automatic wr_reg(input logic [7:0] idx, input int data);
		bus_access({idx, 2'b00}, 1'b1, data, 4'h1, rd);
		if (wmask.exists(idx))
			rmodel[idx] = data & wmask[idx];
		if (idx == liu_port_loop_config_pkg::IDX_LOOP_IRQ_STAT)
			lstat &= ~data;
		if (idx == liu_port_loop_config_pkg::IDX_CLK_IRQ_STAT)
			cstat &= ~data;
	endtask

	task automatic rd_reg(input logic [7:0] idx);
		int e;
		e = rmodel.exists(idx) ? rmodel[idx] : 0;
		if (idx == liu_port_loop_config_pkg::IDX_LOOP_IRQ_STAT)
			e = lstat;
		if (idx == liu_port_loop_config_pkg::IDX_CLK_IRQ_STAT)
			e = cstat;
		bus_access({idx, 2'b00}, 1'b0, 32'h0, 4'h1, rd);
		check_reg(rd, e);
	endtask

	task automatic add_reg(input logic [7:0] idx, input int rst, input int wm);
		rmodel[idx] = rst;
		wmask[idx] = wm;
	endtask

	// ======================================================================
	// One detection run; valid drops afterwards so the next run starts fresh
	task automatic detect(input int mode, input logic up, input logic loc, input longint steps,
		input logic fires);
		wr_reg(liu_port_loop_config_pkg::IDX_LOOP_DET_TIME, mode * 16);
		@(posedge i_clk);
		i_loop_code_is_up <= up;
		i_local_loop_enable <= loc;
		i_loop_pattern_valid <= 1'b1;
		for (longint s = 0; s < steps; s++) begin
			@(posedge i_clk);
			i_loop_pattern_tick <= (mode < 2);
			if (mode < 2) begin
				@(posedge i_clk);
				i_loop_pattern_tick <= 1'b0;
			end
		end
		@(posedge i_clk);
		i_loop_pattern_valid <= 1'b0;
		repeat (2) @(posedge i_clk);
		if (fires) begin
			lstat |= up ? 2 : 1;
			if (rmodel[liu_port_loop_config_pkg::IDX_REMOTE_AUTO][0] && !loc)
				rem_exp = up;
		end
		rd_reg(liu_port_loop_config_pkg::IDX_LOOP_IRQ_STAT);
		@(negedge i_clk);
		check_pin(o_remote_loop, rem_exp[0]);
		check_pin(o_irq, irq_exp());
		wr_reg(liu_port_loop_config_pkg::IDX_LOOP_IRQ_STAT, 3);
	endtask

	// ======================================================================
	// Main sequence
	initial begin
		void'($urandom(32'h54abb279));
		add_reg(liu_port_loop_config_pkg::IDX_RCLK_ROUTE_67, 'h65, 'h77);
		add_reg(liu_port_loop_config_pkg::IDX_RCLK_ROUTE_8, 'h07, 'h07);
		add_reg(liu_port_loop_config_pkg::IDX_LOOP_DET_TIME, 0, 'h30);
		add_reg(liu_port_loop_config_pkg::IDX_REMOTE_AUTO, 0, 'h01);
		add_reg(liu_port_loop_config_pkg::IDX_LOOP_IRQ_MASK, 0, 'h03);
		add_reg(liu_port_loop_config_pkg::IDX_CLK_IRQ_MASK, 0, 'h18);
		add_reg(liu_port_loop_config_pkg::IDX_RAIL_MODE, 0, 'h03);
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1'b1;
		foreach (rmodel[k])
			rd_reg(8'(k));
		foreach (rmodel[k]) begin
			wr_reg(8'(k), $urandom);
			rd_reg(8'(k));
		end
		rd_reg(8'h10);
		bus_access({liu_port_loop_config_pkg::IDX_RAIL_MODE, 2'b01}, 1'b0, 32'h0, 4'h1, rd);
		check_reg(rd, 32'h0);
		bus_access({liu_port_loop_config_pkg::IDX_RAIL_MODE, 2'b00}, 1'b1, 32'h3, 4'h0, rd);
		rd_reg(liu_port_loop_config_pkg::IDX_RAIL_MODE);
		// Every channel code on every routed output
		for (int c = 0; c < 8; c++) begin
			wr_reg(liu_port_loop_config_pkg::IDX_RCLK_ROUTE_67, c * 16 + (7 - c));
			wr_reg(liu_port_loop_config_pkg::IDX_RCLK_ROUTE_8, c);
			repeat (3) begin
				@(posedge i_clk);
				i_chan_rclk <= 8'($urandom);
				@(posedge i_clk);
				@(negedge i_clk);
				check_pin(o_recovered_clock_out_6, i_chan_rclk[7 - c]);
				check_pin(o_recovered_clock_out_7, i_chan_rclk[c]);
				check_pin(o_recovered_clock_out_8, i_chan_rclk[c]);
			end
		end
		for (int d = 0; d < 4; d++) begin
			wr_reg(liu_port_loop_config_pkg::IDX_RAIL_MODE, d);
			@(posedge i_clk);
			@(negedge i_clk);
			check_pin(o_rx_framer_dual_rail, d[1]);
			check_pin(o_tx_framer_dual_rail, d[0]);
		end
		// Loop code detection, exact thresholds either side in pattern modes, a few cycles either side in time modes
		wr_reg(liu_port_loop_config_pkg::IDX_LOOP_IRQ_MASK, 0);
		wr_reg(liu_port_loop_config_pkg::IDX_CLK_IRQ_MASK, 0);
		wr_reg(liu_port_loop_config_pkg::IDX_REMOTE_AUTO, 0);
		detect(0, 1'b1, 1'b0, 16, 1'b1);
		// Only the line side is ever enabled; the system side stays off
		wr_reg(liu_port_loop_config_pkg::IDX_REMOTE_AUTO, 1);
		detect(0, 1'b1, 1'b0, 15, 1'b0);
		detect(0, 1'b1, 1'b0, 16, 1'b1);
		detect(1, 1'b0, 1'b0, 31, 1'b0);
		detect(1, 1'b0, 1'b0, 32, 1'b1);
		detect(2, 1'b1, 1'b0, SHORT_CYC - 4, 1'b0);
		detect(2, 1'b1, 1'b0, SHORT_CYC + 3, 1'b1);
		detect(3, 1'b0, 1'b0, LONG_CYC - 4, 1'b0);
		detect(3, 1'b0, 1'b0, LONG_CYC + 3, 1'b1);
		detect(0, 1'b1, 1'b1, 16, 1'b1);
		wr_reg(liu_port_loop_config_pkg::IDX_LOOP_IRQ_MASK, 3);
		detect(0, 1'b1, 1'b0, 16, 1'b1);
		// Clock switch events, masked and unmasked
		for (int b = 0; b < 2; b++)
			for (int m = 0; m < 2; m++) begin
				wr_reg(liu_port_loop_config_pkg::IDX_CLK_IRQ_MASK, m * (8 << b));
				@(posedge i_clk);
				i_tx_clock_switch_event <= 2'(1 << b);
				@(posedge i_clk);
				i_tx_clock_switch_event <= 2'h0;
				repeat (2) @(posedge i_clk);
				cstat |= 8 << b;
				rd_reg(liu_port_loop_config_pkg::IDX_CLK_IRQ_STAT);
				@(negedge i_clk);
				check_pin(o_irq, irq_exp());
				wr_reg(liu_port_loop_config_pkg::IDX_CLK_IRQ_STAT, 'h18);
			end
		rd_reg(liu_port_loop_config_pkg::IDX_CLK_IRQ_STAT);
		finish_test();
	end
endmodule // liu_port_loop_config_regs_tb
